// ### gtm_edge_det.sv
/*
  capture pin synchroniser and edge detector.
  assumes the pin level is held two clocks after every edge.
*/
`timescale 1ns/1ps
`default_nettype none
module gtm_edge_det
(
  input  wire logic       clk_sys,   // system clock
  input  wire logic       rst,       // synchronous reset
  input  wire logic       pin_in,    // raw capture pin
  input  wire logic [1:0] evt_sel,   // edge event select
  output logic            edge_hit   // selected edge seen
);
  logic sync1_ff;  // first stage, read only by sync2
  logic sync2_ff;  // settled level
  logic prev_ff;   // previous settled level

  // two-flop synchroniser then compare of successive samples
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // pick rising, falling or both
  always_comb
  begin
    case (evt_sel)
      gtm_pkg::EVT_RISE: edge_hit = sync2_ff & ~prev_ff;
      gtm_pkg::EVT_FALL: edge_hit = ~sync2_ff & prev_ff;
      gtm_pkg::EVT_BOTH: edge_hit = sync2_ff ^ prev_ff;
      default:           edge_hit = 1'b0;
    endcase
  end
endmodule // gtm_edge_det
`default_nettype wire

// ### gtm_pin_model.sv
/*
  capture pin source standing in for the outside world: on a start pulse it
  makes n_edges level changes, one every half+1 clocks.
  assumes half stays at 2 or more so each level is held long enough.
*/
`timescale 1ns/1ps
`default_nettype none
module gtm_pin_model
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst,      // synchronous reset
  input  wire logic       start,    // begin a burst of edges
  input  wire logic [7:0] n_edges,  // level changes in the burst
  input  wire logic [3:0] half,     // clocks between changes minus one
  output logic            ccp_in,   // pin level seen by the timer
  output logic            busy      // burst in progress
);
  logic [7:0] left_ff;  // changes still to make
  logic [3:0] cnt_ff;   // wait before next change

  // pin toggler; each level stands half+1 clocks, at least three while half is 2 or more
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ccp_in  <= 1'b0;
      busy    <= 1'b0;
      left_ff <= 8'h00;
      cnt_ff  <= 4'h0;
    end
    else if (start && !busy && n_edges != 8'h00)
    begin
      busy    <= 1'b1;
      left_ff <= n_edges;
      cnt_ff  <= half;
    end
    else if (busy && cnt_ff == 4'h0)
    begin
      // change the level, then hold it a full span
      ccp_in  <= ~ccp_in;
      cnt_ff  <= half;
      left_ff <= left_ff - 8'h01;
      busy    <= (left_ff != 8'h01);
    end
    else if (busy)
    begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // gtm_pin_model
`default_nettype wire

// ### gtm_pkg.sv
/*
  package for the general timer module 16-bit timer half: register offsets,
  field positions, reset values, mode codes and edge timing counts.
  assumes a 32-bit apb slave with word-aligned registers and a 10 MHz clk_sys.
*/
package gtm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_MODE  = 8'h04;
  localparam logic [7:0] OFS_CTL   = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] OFS_RIS   = 8'h1c;
  localparam logic [7:0] OFS_MIS   = 8'h20;
  localparam logic [7:0] OFS_ICLR  = 8'h24;
  localparam logic [7:0] OFS_LOAD  = 8'h28;
  localparam logic [7:0] OFS_MATCH = 8'h30;
  localparam logic [7:0] OFS_PRE   = 8'h38;
  localparam logic [7:0] OFS_CAPT  = 8'h48;
  localparam logic [7:0] OFS_COUNT = 8'h50;
  // config and mode field values
  localparam logic [2:0] CFG_SPLIT    = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIOD  = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  // mode register field positions
  localparam int MODE_LSB = 0;
  localparam int CMR_BIT  = 2;
  localparam int AMS_BIT  = 3;
  // control register field positions
  localparam int EN_BIT    = 0;
  localparam int STALL_BIT = 1;
  localparam int EVT_LSB   = 2;
  localparam int INV_BIT   = 6;
  // status bit positions: timeout, count match, edge event
  localparam int ST_TO = 0;
  localparam int ST_CM = 1;
  localparam int ST_CE = 2;
  // edge event select codes
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_BOTH = 2'h3;
  // reset values
  localparam logic [15:0] RST_LOAD = 16'hffff;
  localparam logic [7:0]  RST_PRE  = 8'h00;
  // input hold time after an edge and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int EDGE_HOLD_NS  = 200;
  localparam int EDGE_HOLD_CYC = (EDGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : gtm_pkg

// ### gtm_prescale.sv
/*
  8-bit prescaler giving a one-cycle count enable every p+1 clocks.
  assumes the caller reloads it when the main counter reloads.
*/
`timescale 1ns/1ps
`default_nettype none
module gtm_prescale
#(
  parameter int PW = 8  // prescaler width
)
(
  input  wire logic          clk_sys,  // system clock
  input  wire logic          rst,      // synchronous reset
  input  wire logic          run,      // counting allowed
  input  wire logic          reload,   // restart from setting
  input  wire logic [PW-1:0] pre_val,  // prescale setting p
  output logic               tick      // one-cycle count enable
);
  logic [PW-1:0] cnt_ff;  // down-count of remaining clocks

  // tick when the residue is zero, then restart at p
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (reload)
      cnt_ff <= pre_val;
    else if (run)
      cnt_ff <= (cnt_ff == '0) ? pre_val : cnt_ff - 1'b1;
  end

  assign tick = run && (cnt_ff == '0);
endmodule // gtm_prescale
`default_nettype wire

// ### gtm_timer.sv
/*
  one 16-bit timer half with apb registers: one-shot, periodic, edge count,
  edge time and pwm modes. one instance serves each of the two halves.
  assumes an apb master, a debug halt level and an asynchronous capture pin.
*/
`timescale 1ns/1ps
`default_nettype none
module gtm_timer
#(
  parameter int CW = 16,  // counter width
  parameter int PW = 8    // prescaler width
)
(
  input  wire logic        clk_sys,     // system clock
  input  wire logic        rst,         // synchronous reset
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error
  input  wire logic        debug_halt,  // processor halted by debugger
  input  wire logic        ccp_in,      // capture_compare_pin input
  output logic             ccp_out,     // capture_compare_pin pwm drive
  output logic             ccp_oe,      // capture_compare_pin output enable
  output logic             irq          // masked flag summary
);
  typedef enum logic [2:0] {M_IDLE, M_ONESHOT, M_PERIOD, M_ECOUNT, M_ETIME, M_PWM} gtm_mode_e;

  logic [2:0]    cfg_ff;          // timer_config_register
  logic [3:0]    tmode_ff;        // timer_mode_register
  logic          run_ff;          // timer_run_enable
  logic          stall_ff;        // debug_stall_enable
  logic [1:0]    evt_ff;          // edge_event_select
  logic          inv_ff;          // pwm_output_invert
  logic [2:0]    imask_ff;        // interrupt_mask_register
  logic [2:0]    ris_ff;          // raw_interrupt_status
  logic [CW-1:0] load_ff;         // interval_load_value
  logic [CW-1:0] match_ff;        // match_value
  logic [PW-1:0] pre_ff;          // prescale_value
  logic [CW-1:0] cnt_ff;          // running count
  logic [CW-1:0] capt_ff;         // captured_count_value
  logic          wrapped_ff;      // count reached zero last step
  logic          pwm_ff;          // pwm level before invert
  logic          load_wr_ff;      // load written last cycle
  logic [31:0]   prdata_ff;       // read data register
  logic          pready_ff;       // ready register
  logic          pslverr_ff;      // error register
  logic          ccp_out_ff;      // pin drive register
  logic          ccp_oe_ff;       // pin enable register
  logic          irq_ff;          // interrupt register
  gtm_mode_e     mode;            // decoded mode
  logic          wr_acc;          // write in setup phase
  logic          rd_acc;          // read in setup phase
  logic          hit;             // address maps a register
  logic          freeze;          // debug stall active
  logic          tick;            // prescaled count enable
  logic          edge_hit;        // selected edge
  logic          step;            // counter moves this cycle
  logic          at_zero;         // counter is zero
  logic          cm_set;          // count match event
  logic          to_set;          // timeout event
  logic          ce_set;          // edge event
  logic [2:0]    nxt_ris;         // next raw status

  // decode the mode from config and mode register fields; same decode serves either half
  always_comb
  begin
    mode = M_IDLE;
    if (cfg_ff == gtm_pkg::CFG_SPLIT)
    begin
      case (tmode_ff[gtm_pkg::MODE_LSB +: 2])
        gtm_pkg::MODE_ONESHOT: mode = M_ONESHOT;
        gtm_pkg::MODE_PERIOD:
          mode = (tmode_ff[gtm_pkg::AMS_BIT] && !tmode_ff[gtm_pkg::CMR_BIT]) ? M_PWM : M_PERIOD;
        gtm_pkg::MODE_CAPTURE:
          mode = tmode_ff[gtm_pkg::CMR_BIT] ? M_ETIME : M_ECOUNT;
        default: mode = M_IDLE;
      endcase
    end
  end

  // apb decode: answer in the access phase with no wait state
  assign wr_acc = psel && !penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  always_comb
  begin
    case (paddr)
      gtm_pkg::OFS_CFG, gtm_pkg::OFS_MODE, gtm_pkg::OFS_CTL, gtm_pkg::OFS_IMASK,
      gtm_pkg::OFS_RIS, gtm_pkg::OFS_MIS, gtm_pkg::OFS_ICLR, gtm_pkg::OFS_LOAD,
      gtm_pkg::OFS_MATCH, gtm_pkg::OFS_PRE, gtm_pkg::OFS_CAPT, gtm_pkg::OFS_COUNT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign freeze  = stall_ff && debug_halt;
  assign at_zero = (cnt_ff == '0);

  gtm_prescale #(.PW(PW)) u_pre
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (run_ff && !freeze && (mode == M_ONESHOT || mode == M_PERIOD)),
    .reload  (wrapped_ff || !run_ff),  // held at p while stopped so the first count also takes p+1
    .pre_val (pre_ff),
    .tick    (tick)
  );

  gtm_edge_det u_edge
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   (ccp_in),
    .evt_sel  (evt_ff),
    .edge_hit (edge_hit)
  );

  // when the counter advances; edge modes bypass the prescaler
  always_comb
  begin
    case (mode)
      M_ONESHOT, M_PERIOD: step = tick;
      M_ETIME, M_PWM:      step = run_ff && !freeze;
      M_ECOUNT:            step = run_ff && !freeze && edge_hit;
      default:             step = 1'b0;
    endcase
  end

  assign to_set = (mode == M_ONESHOT || mode == M_PERIOD) && step && at_zero && !wrapped_ff;
  assign cm_set = (mode == M_ECOUNT) && run_ff && (cnt_ff == match_ff);
  assign ce_set = (mode == M_ETIME) && run_ff && !freeze && edge_hit;

  // software register writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_ff   <= '0;
      tmode_ff <= '0;
      stall_ff <= 1'b0;
      evt_ff   <= gtm_pkg::EVT_RISE;
      inv_ff   <= 1'b0;
      imask_ff <= '0;
      load_ff  <= gtm_pkg::RST_LOAD;
      match_ff <= '0;
      pre_ff   <= gtm_pkg::RST_PRE;
    end
    else if (wr_acc)
    begin
      case (paddr)
        gtm_pkg::OFS_CFG:   cfg_ff   <= pwdata[2:0];
        gtm_pkg::OFS_MODE:  tmode_ff <= pwdata[3:0];
        gtm_pkg::OFS_CTL:
        begin
          stall_ff <= pwdata[gtm_pkg::STALL_BIT];
          evt_ff   <= pwdata[gtm_pkg::EVT_LSB +: 2];
          inv_ff   <= pwdata[gtm_pkg::INV_BIT];
        end
        gtm_pkg::OFS_IMASK: imask_ff <= pwdata[2:0];
        gtm_pkg::OFS_LOAD:  load_ff  <= pwdata[CW-1:0];
        gtm_pkg::OFS_MATCH: match_ff <= pwdata[CW-1:0];
        gtm_pkg::OFS_PRE:   pre_ff   <= pwdata[PW-1:0];
        default: ;
      endcase
    end
  end

  // run enable: software writes, hardware clears after one-shot or match
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      run_ff <= 1'b0;
    else if (mode == M_ONESHOT && wrapped_ff)
      run_ff <= 1'b0;
    else if (cm_set)
      run_ff <= 1'b0;
    else if (wr_acc && paddr == gtm_pkg::OFS_CTL)
      run_ff <= pwdata[gtm_pkg::EN_BIT];
  end

  // note that a load write happened, taken next cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      load_wr_ff <= 1'b0;
    else
      load_wr_ff <= wr_acc && (paddr == gtm_pkg::OFS_LOAD);
  end

  // the counter itself
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_ff     <= gtm_pkg::RST_LOAD;
      wrapped_ff <= 1'b0;
    end
    else if (!run_ff)
    begin
      cnt_ff     <= load_ff;           // preload while stopped
      wrapped_ff <= 1'b0;
    end
    else if (cm_set)
    begin
      cnt_ff     <= load_ff;
      wrapped_ff <= 1'b0;
    end
    else if (load_wr_ff)
    begin
      cnt_ff     <= load_ff;
      wrapped_ff <= 1'b0;
    end
    else if (wrapped_ff && !freeze)
    begin
      cnt_ff     <= load_ff;
      wrapped_ff <= 1'b0;
    end
    else if (step && !wrapped_ff)
    begin
      if (at_zero)
        wrapped_ff <= (mode != M_ECOUNT);
      else
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // raw status: set wins over clear
  always_comb
  begin
    nxt_ris = ris_ff;
    if (wr_acc && paddr == gtm_pkg::OFS_ICLR)
      nxt_ris = ris_ff & ~pwdata[2:0];
    nxt_ris[gtm_pkg::ST_TO] = nxt_ris[gtm_pkg::ST_TO] | to_set;
    nxt_ris[gtm_pkg::ST_CM] = nxt_ris[gtm_pkg::ST_CM] | cm_set;
    nxt_ris[gtm_pkg::ST_CE] = nxt_ris[gtm_pkg::ST_CE] | ce_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ris_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      ris_ff <= nxt_ris;
      irq_ff <= |(nxt_ris & imask_ff);
    end
  end

  // capture count on each edge in edge time mode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      capt_ff <= gtm_pkg::RST_LOAD;
    else if (ce_set)
      capt_ff <= cnt_ff;
  end

  // pwm: high at load value, low at match, no flags
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pwm_ff     <= 1'b0;
      ccp_out_ff <= 1'b0;
      ccp_oe_ff  <= 1'b0;
    end
    else
    begin
      if (cnt_ff == load_ff)
        pwm_ff <= 1'b1;
      else if (cnt_ff == match_ff)
        pwm_ff <= 1'b0;
      ccp_out_ff <= (mode == M_PWM) && run_ff && (pwm_ff ^ inv_ff);
      ccp_oe_ff  <= (mode == M_PWM);
    end
  end

  // apb read data and response
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !hit;
      prdata_ff  <= '0;
      if (rd_acc)
      begin
        case (paddr)
          gtm_pkg::OFS_CFG:   prdata_ff <= {29'h0, cfg_ff};
          gtm_pkg::OFS_MODE:  prdata_ff <= {28'h0, tmode_ff};
          gtm_pkg::OFS_CTL:   prdata_ff <= {25'h0, inv_ff, 2'h0, evt_ff, stall_ff, run_ff};
          gtm_pkg::OFS_IMASK: prdata_ff <= {29'h0, imask_ff};
          gtm_pkg::OFS_RIS:   prdata_ff <= {29'h0, ris_ff};
          gtm_pkg::OFS_MIS:   prdata_ff <= {29'h0, ris_ff & imask_ff};
          gtm_pkg::OFS_LOAD:  prdata_ff <= {16'h0, load_ff};
          gtm_pkg::OFS_MATCH: prdata_ff <= {16'h0, match_ff};
          gtm_pkg::OFS_PRE:   prdata_ff <= {24'h0, pre_ff};
          gtm_pkg::OFS_CAPT:  prdata_ff <= {16'h0, (mode == M_ETIME) ? capt_ff : cnt_ff};
          gtm_pkg::OFS_COUNT: prdata_ff <= {16'h0, cnt_ff};
          default:            prdata_ff <= '0;
        endcase
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign ccp_out = ccp_out_ff;
  assign ccp_oe  = ccp_oe_ff;
  assign irq     = irq_ff;

  // one-shot clears run on the same edge as the reload
  AST_ONESHOT_STOP: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == M_ONESHOT && wrapped_ff) |=> !run_ff) else $error("one-shot kept running");
  // timeout raises the raw flag next cycle
  AST_TO_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
    to_set |=> ris_ff[gtm_pkg::ST_TO]) else $error("timeout flag missing");
  // reload after zero
  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (rst)
    (run_ff && wrapped_ff && !freeze && !cm_set && !load_wr_ff) |=> cnt_ff == $past(load_ff))
    else $error("no reload after zero");
  // load write taken on the next cycle
  AST_LOAD_NEXT: assert property (@(posedge clk_sys) disable iff (rst)
    (run_ff && load_wr_ff && !cm_set) |=> cnt_ff == $past(load_ff)) else $error("load not taken");
  // stall freezes the count
  AST_STALL: assert property (@(posedge clk_sys) disable iff (rst)
    (run_ff && freeze && !load_wr_ff && !cm_set && !(mode == M_ONESHOT && wrapped_ff)) |=> $stable(cnt_ff))
    else $error("count moved while stalled");
  // match stops edge counting
  AST_MATCH_STOP: assert property (@(posedge clk_sys) disable iff (rst)
    cm_set |=> (!run_ff && ris_ff[gtm_pkg::ST_CM])) else $error("edge count did not stop");
  // edge time capture
  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
    ce_set |=> (capt_ff == $past(cnt_ff) && ris_ff[gtm_pkg::ST_CE])) else $error("capture wrong");
  // pwm sets no flags
  AST_PWM_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == M_PWM) |=> ((ris_ff & ~$past(ris_ff)) == 3'h0)) else $error("flag in pwm mode");
  // edge count decrements by one
  AST_ECOUNT_DEC: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == M_ECOUNT && step && !cm_set && !at_zero && !load_wr_ff) |=> cnt_ff == $past(cnt_ff) - 16'h0001)
    else $error("edge count step wrong");
endmodule // gtm_timer
`default_nettype wire

// ### tb_top.sv
/*
  self-checking testbench for gtm_timer: apb tasks, one scenario per mode.
  assumes gtm_pkg and gtm_pin_model; one-cycle apb answer.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, rst, psel, penable, pwrite, debug_halt;  // design inputs
  logic [7:0]  paddr;                                           // apb address
  logic [31:0] pwdata, prdata, rdata, sv;                       // bus data, read copies
  logic        pready, pslverr, rerr, ccp_in, ccp_out, ccp_oe, irq;
  logic        pin_go, pin_busy;                                // pin model control
  logic [7:0]  pin_n;                                           // edges per burst
  int          miscompares, n_checks, c0, c1, hi0, hi1;         // counters

  gtm_timer u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .irq(irq));
  gtm_pin_model u_pin (.clk_sys(clk_sys), .rst(rst), .start(pin_go), .n_edges(pin_n),
    .half(4'h3), .ccp_in(ccp_in), .busy(pin_busy));

  // 100 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic results();
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // masked read compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, exp);
  endtask

  // burst of pin edges, then time for the synchroniser
  task automatic edges(input logic [7:0] n);
    int k;
    pin_n  <= n;
    pin_go <= 1'b1;
    @(posedge clk_sys);
    pin_go <= 1'b0;
    @(posedge clk_sys);
    k = 0;
    while (pin_busy === 1'b1 && k < 500)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 500)
      chk(32'h0, 32'h1);
    repeat (6) @(posedge clk_sys);
  endtask

  // one-shot run; cycles from start to interrupt
  task automatic run_once(input logic [7:0] p, output int cyc);
    wr(gtm_pkg::OFS_PRE, {24'h0, p});
    wr(gtm_pkg::OFS_ICLR, 32'h7);
    wr(gtm_pkg::OFS_CTL, 32'h1);
    cyc = 0;
    while (irq !== 1'b1 && cyc < 3000)
    begin
      @(posedge clk_sys);
      cyc++;
    end
    if (cyc >= 3000)
      chk(32'h0, 32'h1);
  endtask

  // pwm high cycles over 110 clocks, after settling
  task automatic pwm_hi(input logic [31:0] ctl, output int hi);
    wr(gtm_pkg::OFS_CTL, ctl);
    repeat (22) @(posedge clk_sys);
    hi = 0;
    repeat (110)
    begin
      @(posedge clk_sys);
      hi += (ccp_out === 1'b1);
    end
    chk({31'h0, ccp_oe}, 32'h1);
    wr(gtm_pkg::OFS_CTL, 32'h0);
  endtask

  // hang guard
  initial
  begin
    #3000000;
    miscompares++;
    results();
  end

  initial
  begin
    {psel, penable, pwrite, debug_halt, pin_go} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_n = 8'h00;
    miscompares = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(gtm_pkg::OFS_LOAD, 32'hffff, 32'hffff);
    rd_chk(gtm_pkg::OFS_COUNT, 32'hffff, 32'hffff);
    rd_chk(gtm_pkg::OFS_PRE, 32'hff, 32'h0);
    rd_chk(8'hfc, 32'hffffffff, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // one-shot, two prescales
    wr(gtm_pkg::OFS_CFG, 32'h4);
    wr(gtm_pkg::OFS_MODE, 32'h1);
    wr(gtm_pkg::OFS_LOAD, 32'h3);
    wr(gtm_pkg::OFS_IMASK, 32'h1);
    run_once(8'h00, c0);
    run_once(8'hff, c1);
    chk(32'(c1 - c0), 32'd1020);
    chk({31'h0, irq}, 32'h1);
    rd_chk(gtm_pkg::OFS_CTL, 32'h1, 32'h0);
    rd_chk(gtm_pkg::OFS_MIS, 32'h1, 32'h1);
    rd_chk(gtm_pkg::OFS_COUNT, 32'hffff, 32'h3);
    wr(gtm_pkg::OFS_ICLR, 32'h1);
    rd_chk(gtm_pkg::OFS_RIS, 32'h1, 32'h0);
    // periodic, reload on the fly, debug stall
    wr(gtm_pkg::OFS_PRE, 32'h0);
    wr(gtm_pkg::OFS_MODE, 32'h2);
    wr(gtm_pkg::OFS_LOAD, 32'h4);
    wr(gtm_pkg::OFS_CTL, 32'h1);
    repeat (30) @(posedge clk_sys);
    rd_chk(gtm_pkg::OFS_CTL, 32'h1, 32'h1);
    rd_chk(gtm_pkg::OFS_RIS, 32'h1, 32'h1);
    wr(gtm_pkg::OFS_LOAD, 32'h100);
    apb(1'b0, gtm_pkg::OFS_COUNT, 32'h0);
    chk({31'h0, rdata <= 32'h100 && rdata > 32'hf0}, 32'h1);
    wr(gtm_pkg::OFS_CTL, 32'h3);
    debug_halt <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, gtm_pkg::OFS_COUNT, 32'h0);
    sv = rdata;
    repeat (8) @(posedge clk_sys);
    rd_chk(gtm_pkg::OFS_COUNT, 32'hffff, sv);
    debug_halt <= 1'b0;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, gtm_pkg::OFS_COUNT, 32'h0);
    chk({31'h0, rdata != sv}, 32'h1);
    // edge count, both edges, 10 down to 6
    wr(gtm_pkg::OFS_CTL, 32'h0);
    wr(gtm_pkg::OFS_MODE, 32'h3);
    wr(gtm_pkg::OFS_LOAD, 32'ha);
    wr(gtm_pkg::OFS_MATCH, 32'h6);
    wr(gtm_pkg::OFS_ICLR, 32'h7);
    wr(gtm_pkg::OFS_IMASK, 32'h2);
    wr(gtm_pkg::OFS_CTL, 32'hd);
    edges(8'h3);
    rd_chk(gtm_pkg::OFS_COUNT, 32'hffff, 32'h7);
    rd_chk(gtm_pkg::OFS_RIS, 32'h2, 32'h0);
    edges(8'h1);
    rd_chk(gtm_pkg::OFS_RIS, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd_chk(gtm_pkg::OFS_CTL, 32'h1, 32'h0);
    edges(8'h2);
    rd_chk(gtm_pkg::OFS_COUNT, 32'hffff, 32'ha);
    // edge time, rising then falling selection
    wr(gtm_pkg::OFS_MODE, 32'h7);
    wr(gtm_pkg::OFS_LOAD, 32'hffff);
    wr(gtm_pkg::OFS_IMASK, 32'h4);
    for (int e = 0; e < 2; e++)
    begin
      wr(gtm_pkg::OFS_ICLR, 32'h7);
      wr(gtm_pkg::OFS_CTL, {28'h0, (e == 0) ? gtm_pkg::EVT_RISE : gtm_pkg::EVT_FALL, 2'b01});
      edges(8'h1);
      rd_chk(gtm_pkg::OFS_RIS, 32'h4, 32'h4);
      apb(1'b0, gtm_pkg::OFS_CAPT, 32'h0);
      sv = rdata;
      chk({31'h0, sv < 32'hffff}, 32'h1);
      repeat (20) @(posedge clk_sys);
      rd_chk(gtm_pkg::OFS_CAPT, 32'hffff, sv);
      rd_chk(gtm_pkg::OFS_CTL, 32'h1, 32'h1);
    end
    // pwm, plain then inverted
    wr(gtm_pkg::OFS_CTL, 32'h0);
    wr(gtm_pkg::OFS_MODE, 32'ha);
    wr(gtm_pkg::OFS_LOAD, 32'h9);
    wr(gtm_pkg::OFS_MATCH, 32'h4);
    wr(gtm_pkg::OFS_ICLR, 32'h7);
    wr(gtm_pkg::OFS_PRE, 32'hff);
    pwm_hi(32'h01, hi0);
    pwm_hi(32'h41, hi1);
    chk(32'(hi0), 32'd50);
    chk(32'(hi0 + hi1), 32'd110);
    rd_chk(gtm_pkg::OFS_RIS, 32'h7, 32'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire
